// ===== alarm_eval.sv
// Purpose: Shared constants and carrier types, and the per-alarm threshold evaluator.
// Assumes: Temperatures and thresholds are signed words of the same scale.
// Notes:   The evaluator is purely combinational; the caller holds the state.
package alarm_pkg;
   localparam int          NUM_ALARMS        = 8;
   localparam int          NUM_CHANNELS      = 8;
   localparam int          TEMP_W            = 16;
   localparam int          ADDR_W            = 8;
   localparam int          NV_WORDS          = 24;
   // Timing
   localparam int          CLK_PERIOD_NS     = 4;
   localparam int          SAMPLE_PERIOD_MS  = 500;
   localparam int          HALF_SEC_CYCLES   = SAMPLE_PERIOD_MS * (1000000 / CLK_PERIOD_NS);
   // Register regions (address bits 7:3), entry index in bits 2:0
   localparam logic [4:0]  REGION_CFG        = 5'h00;
   localparam logic [4:0]  REGION_FIRST      = 5'h01;
   localparam logic [4:0]  REGION_SECOND     = 5'h02;
   localparam logic [4:0]  REGION_TEMP       = 5'h03;
   localparam logic [4:0]  REGION_MISC       = 5'h04;
   localparam logic [2:0]  MISC_GP_DIR       = 3'h0;
   localparam logic [2:0]  MISC_GP_OUT       = 3'h1;
   localparam logic [2:0]  MISC_GP_IN        = 3'h2;
   localparam logic [2:0]  MISC_ALARM        = 3'h3;
   localparam logic [2:0]  MISC_STATUS       = 3'h4;
   // Reset values
   localparam logic [7:0]  GP_DIR_RESET      = 8'h00;
   localparam logic [7:0]  GP_OUT_RESET      = 8'h00;
   localparam logic [15:0] THRESH_RESET      = 16'h0000;

   typedef enum logic [1:0] {
      OUT_DISABLED    = 2'h0,
      OUT_ACTIVE_HIGH = 2'h1,
      OUT_ACTIVE_LOW  = 2'h2
   } out_mode_e;

   typedef enum logic [2:0] {
      IN_ABOVE        = 3'h0,
      IN_ABOVE_HYST   = 3'h1,
      IN_BELOW        = 3'h2,
      IN_BELOW_HYST   = 3'h3,
      IN_WINDOW       = 3'h4
   } in_mode_e;

   // Config word layout: [7:5] channel, [4:2] input mode, [1:0] output mode
   typedef struct packed {
      logic [2:0] chan;
      in_mode_e   in_mode;
      out_mode_e  out_mode;
   } alarm_cfg_s;

   localparam alarm_cfg_s CFG_RESET = '{chan: 3'h0, in_mode: IN_ABOVE, out_mode: OUT_DISABLED};

   typedef struct packed {
      logic              valid;
      logic [2:0]        chan;
      logic [TEMP_W-1:0] data;
   } sample_s;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [4:0]        addr;
      logic [TEMP_W-1:0] wdata;
   } nv_req_s;
endpackage : alarm_pkg

`timescale 1ns/1ps

module alarm_eval (
   input  wire logic                      i_prev,
   input  wire alarm_pkg::in_mode_e       i_mode,
   input  wire logic [alarm_pkg::TEMP_W-1:0] i_temp,
   input  wire logic [alarm_pkg::TEMP_W-1:0] i_first,
   input  wire logic [alarm_pkg::TEMP_W-1:0] i_second,
   output logic                           o_next
);
   logic gt_first;
   logic lt_first;
   logic gt_second;
   logic lt_second;

   assign gt_first  = $signed(i_temp) > $signed(i_first);
   assign lt_first  = $signed(i_temp) < $signed(i_first);
   assign gt_second = $signed(i_temp) > $signed(i_second);
   assign lt_second = $signed(i_temp) < $signed(i_second);

   always_comb begin
      case (i_mode)
         alarm_pkg::IN_ABOVE:      o_next = gt_first;                                  // [R7]
         alarm_pkg::IN_ABOVE_HYST: o_next = gt_first ? 1'b1 : (lt_second ? 1'b0 : i_prev); // [R8]
         alarm_pkg::IN_BELOW:      o_next = lt_first;                                  // [R7]
         alarm_pkg::IN_BELOW_HYST: o_next = lt_first ? 1'b1 : (gt_second ? 1'b0 : i_prev); // [R9]
         alarm_pkg::IN_WINDOW:     o_next = lt_first | gt_second;                      // [R7]
         default:                  o_next = 1'b0;
      endcase
   end
endmodule : alarm_eval

// ===== temperature_alarm_dio_unit.sv
// Purpose: Eight temperature alarms driving eight general-purpose lines, with
//          sample store, non-volatile config load, acquisition and log pacing.
// Assumes: Non-volatile store answers a read one cycle after o_nv.rd.
//          The sample source delivers every channel after each acquisition pulse.
// Notes:   Registers are 16-bit words on a plain strobe port; address bits 7:3 pick a
//          region and bits 2:0 an entry i:
//            0x00+i alarm config: [7:5] channel, [4:2] input mode, [1:0] output mode
//            0x08+i first threshold, 0x10+i second threshold, both signed
//            0x18+i latest temperature of channel i, read only
//            0x20 line direction (1 = output), 0x21 line level, 0x22 line input
//            0x23 alarm states, 0x24 bit 0 load done; these three read only
//          Config and threshold writes go to the store in the power-on layout:
//          words 0-7 config, 8-15 first threshold, 16-23 second threshold.
//          Writes before load done are dropped; output mode 3 acts as disabled.
//          Comparisons are strict: a value equal to a threshold lies between them.
//          Writing a config clears its alarm unless an update raises it that cycle.
//
// Behaviour
// [R1] Eight alarm units, each tied to one general-purpose line.
// [R2] Eight general-purpose lines, each independently input or output.
// [R3] After reset every line is an input unless its alarm is enabled.
// [R4] Each alarm selects any of the eight temperature channels as input.
// [R5] Enabled alarm switches its line to output, driven by options and temperature.
// [R6] Alarm configuration lives in non-volatile storage, loaded at power-on.
// [R7] Input modes: above first, below first, or outside first..second window.
// [R8] High hysteresis: set above first threshold, clear below second threshold.
// [R9] Low hysteresis: set below first threshold, clear above second threshold.
// [R10] Each alarm has its own independent first and second thresholds.
// [R11] Output mode disabled leaves the line under normal general-purpose control.
// [R12] Active-high mode drives line high while alarm holds, else low.
// [R13] Active-low mode drives line low while alarm holds, else high.
// [R14] Alarms work both standalone and while the host link is attached.
// [R15] Every channel acquired continuously, two new samples per second.
// [R16] Sample to host presentation delay at most about half a second.
// [R17] Logged samples limited to one per second per channel.
// [R18] Alarms re-evaluated once per second from the latest samples.
// [R19] Hysteresis state held between updates inside the threshold band.
//
// The address map and strobed register access were decided locally.

`timescale 1ns/1ps

module temperature_alarm_dio_unit #(
   parameter int HALF_SEC_CYCLES = alarm_pkg::HALF_SEC_CYCLES
) (
   input  wire logic                              i_clk,
   input  wire logic                              i_resetn,
   // Register port
   input  wire logic [alarm_pkg::ADDR_W-1:0]      i_addr,
   input  wire logic [alarm_pkg::TEMP_W-1:0]      i_wdata,
   input  wire logic                              i_wr,
   input  wire logic                              i_rd,
   output logic      [alarm_pkg::TEMP_W-1:0]      o_rdata,
   // General-purpose lines
   input  wire logic [alarm_pkg::NUM_ALARMS-1:0]  i_gp_in,
   output logic      [alarm_pkg::NUM_ALARMS-1:0]  o_gp_out,
   output logic      [alarm_pkg::NUM_ALARMS-1:0]  o_gp_oe,
   // Acquisition
   output logic                                   o_acq_start,
   input  wire alarm_pkg::sample_s                i_sample,
   // Non-volatile storage
   output alarm_pkg::nv_req_s                     o_nv,
   input  wire logic [alarm_pkg::TEMP_W-1:0]      i_nv_rdata,
   // Logging
   input  wire logic                              i_host_attached,
   input  wire logic                              i_log_run,
   output logic                                   o_log_valid,
   output logic      [alarm_pkg::NUM_CHANNELS-1:0][alarm_pkg::TEMP_W-1:0] o_log_temps
);
   localparam int N     = alarm_pkg::NUM_ALARMS;
   localparam int W     = alarm_pkg::TEMP_W;
   // Pacing counter wide enough for one half period
   localparam int CNT_W = $clog2(HALF_SEC_CYCLES + 1);

   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } phase_e;

   typedef struct packed {
      // Power-on load of the stored configuration
      phase_e                     fsm;
      logic [4:0]                 load_idx;
      logic                       rd_pend;
      logic [4:0]                 rd_addr;
      alarm_pkg::nv_req_s         nv;
      // Alarm setup, latest samples and alarm states
      alarm_pkg::alarm_cfg_s [N-1:0] cfg;
      logic [N-1:0][W-1:0]        first;
      logic [N-1:0][W-1:0]        second;
      logic [alarm_pkg::NUM_CHANNELS-1:0][W-1:0] temps;
      logic [N-1:0]               alarm;
      // Line control
      logic [N-1:0]               gp_dir;
      logic [N-1:0]               gp_out;
      logic [N-1:0]               line_out;
      logic [N-1:0]               line_oe;
      // Read answer, pacing and logging
      logic [W-1:0]               rdata;
      logic [CNT_W-1:0]           half_cnt;
      logic                       odd_half;
      logic                       acq_start;
      logic                       log_valid;
      logic [alarm_pkg::NUM_CHANNELS-1:0][W-1:0] log_temps;
   } state_s;

   state_s st;
   state_s next_st;

   logic [N-1:0] eval_next;
   logic         half_tick;
   logic         sec_tick;
   logic [4:0]   region;
   logic [2:0]   idx;

   assign region    = i_addr[7:3];
   assign idx       = i_addr[2:0];
   // The pacing counter also runs during the load, so acquisition never pauses
   // Every second half tick is the one-second update
   assign half_tick = st.half_cnt == CNT_W'(HALF_SEC_CYCLES - 1);
   assign sec_tick  = half_tick & st.odd_half;

   ////////////////////////////////////////////////////////////////////////////
   // Per-alarm evaluation
   // The previous state feeds the hysteresis modes
   for (genvar g = 0; g < N; g++) begin : g_alarm                               // [R1]
      alarm_eval u_eval (
         .i_prev   (st.alarm[g]),                                                 // [R19]
         .i_mode   (st.cfg[g].in_mode),
         .i_temp   (st.temps[st.cfg[g].chan]),                                    // [R4]
         .i_first  (st.first[g]),                                                 // [R10]
         .i_second (st.second[g]),
         .o_next   (eval_next[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_st           = st;
      next_st.nv        = '0;
      next_st.rdata     = '0;
      next_st.acq_start = 1'b0;
      next_st.log_valid = 1'b0;

      // Half-second pacing for acquisition, one-second for alarms and logging
      if (half_tick) begin
         next_st.half_cnt  = '0;
         next_st.odd_half  = ~st.odd_half;
         next_st.acq_start = 1'b1;                                                // [R15]
      end else begin
         next_st.half_cnt  = st.half_cnt + CNT_W'(1);
      end

      // Latest sample per channel, readable by the host right away
      // A later sample of the same channel overwrites the earlier one
      if (i_sample.valid) begin
         next_st.temps[i_sample.chan] = i_sample.data;                            // [R16]
      end

      // Load sequencer, then run-time register writes
      case (st.fsm)
         ST_LOAD: begin
            // Store answers one cycle after each read, so captures trail requests
            if (st.rd_pend) begin                                                  // [R6]
               case (st.rd_addr[4:3])
                  2'h0:    next_st.cfg[st.rd_addr[2:0]]    = alarm_pkg::alarm_cfg_s'(i_nv_rdata[7:0]);
                  2'h1:    next_st.first[st.rd_addr[2:0]]  = i_nv_rdata;
                  default: next_st.second[st.rd_addr[2:0]] = i_nv_rdata;
               endcase
            end
            // Remember which word is in flight
            next_st.rd_pend = st.nv.rd;
            next_st.rd_addr = st.nv.addr;
            // One read a cycle; leave only once the last answer is in
            if (st.load_idx < 5'(alarm_pkg::NV_WORDS)) begin
               next_st.nv.rd    = 1'b1;
               next_st.nv.addr  = st.load_idx;
               next_st.load_idx = st.load_idx + 5'h1;
            end else if (!st.rd_pend && !st.nv.rd) begin
               next_st.fsm      = ST_RUN;
            end
         end
         ST_RUN: begin
            // Runs regardless of host attachment
            // Alarm states update here once per second; a config write also clears its own alarm
            if (sec_tick) begin                                                    // [R14]
               next_st.alarm = eval_next;                                          // [R18]
            end
            // Keep the store in step with config and threshold writes
            if (i_wr && region <= alarm_pkg::REGION_SECOND) begin
               next_st.nv.wr    = 1'b1;                                            // [R6]
               next_st.nv.addr  = i_addr[4:0];
               next_st.nv.wdata = i_wdata;
            end
            if (i_wr) begin
               case (region)
                  alarm_pkg::REGION_CFG: begin
                     next_st.cfg[idx]    = alarm_pkg::alarm_cfg_s'(i_wdata[7:0]);
                     // A same-cycle update that raises the alarm outranks the clear
                     next_st.alarm[idx]  = sec_tick & eval_next[idx];
                  end
                  alarm_pkg::REGION_FIRST:  next_st.first[idx]  = i_wdata;         // [R10]
                  alarm_pkg::REGION_SECOND: next_st.second[idx] = i_wdata;         // [R10]
                  alarm_pkg::REGION_MISC: begin
                     case (idx)
                        alarm_pkg::MISC_GP_DIR: next_st.gp_dir = i_wdata[N-1:0];  // [R2]
                        alarm_pkg::MISC_GP_OUT: next_st.gp_out = i_wdata[N-1:0];
                        default: ;
                     endcase
                  end
                  default: ;
               endcase
            end
         end
         default: begin
            next_st.fsm = ST_LOAD;
         end
      endcase

      // Logging snapshot once per second
      // Held off while the host link is attached
      if (sec_tick && i_log_run && !i_host_attached) begin
         next_st.log_valid = 1'b1;                                                 // [R17]
         next_st.log_temps = st.temps;
      end

      // Line drive
      // Alarm-enabled lines drive; others follow the general-purpose registers
      for (int k = 0; k < N; k++) begin
         // Until the load is done every line stays an input
         if (st.fsm != ST_RUN) begin
            next_st.line_oe[k]  = 1'b0;                                            // [R3]
            next_st.line_out[k] = 1'b0;
         end else begin
            case (st.cfg[k].out_mode)
               alarm_pkg::OUT_ACTIVE_HIGH: begin
                  next_st.line_oe[k]  = 1'b1;                                      // [R5]
                  next_st.line_out[k] = st.alarm[k];                               // [R12]
               end
               alarm_pkg::OUT_ACTIVE_LOW: begin
                  next_st.line_oe[k]  = 1'b1;                                      // [R5]
                  next_st.line_out[k] = ~st.alarm[k];                              // [R13]
               end
               default: begin
                  next_st.line_oe[k]  = st.gp_dir[k];                              // [R11]
                  next_st.line_out[k] = st.gp_out[k];
               end
            endcase
         end
      end

      // Register reads
      // Read data stands one cycle and is zero otherwise
      if (i_rd) begin
         case (region)
            alarm_pkg::REGION_CFG:    next_st.rdata = {8'h00, st.cfg[idx]};
            alarm_pkg::REGION_FIRST:  next_st.rdata = st.first[idx];
            alarm_pkg::REGION_SECOND: next_st.rdata = st.second[idx];
            alarm_pkg::REGION_TEMP:   next_st.rdata = st.temps[idx];               // [R16]
            alarm_pkg::REGION_MISC: begin
               case (idx)
                  alarm_pkg::MISC_GP_DIR: next_st.rdata = {8'h00, st.gp_dir};
                  alarm_pkg::MISC_GP_OUT: next_st.rdata = {8'h00, st.gp_out};
                  alarm_pkg::MISC_GP_IN:  next_st.rdata = {8'h00, i_gp_in};
                  alarm_pkg::MISC_ALARM:  next_st.rdata = {8'h00, st.alarm};
                  alarm_pkg::MISC_STATUS: next_st.rdata = {15'h0000, st.fsm == ST_RUN};
                  default:                next_st.rdata = '0;
               endcase
            end
            default: next_st.rdata = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   // Config and thresholds hold defaults until the load replaces them
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st           <= '0;
         st.fsm       <= ST_LOAD;
         st.cfg       <= {N{alarm_pkg::CFG_RESET}};
         st.first     <= {N{alarm_pkg::THRESH_RESET}};
         st.second    <= {N{alarm_pkg::THRESH_RESET}};
         st.gp_dir    <= alarm_pkg::GP_DIR_RESET;                                  // [R3]
         st.gp_out    <= alarm_pkg::GP_OUT_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Every output comes straight from the state register
   assign o_rdata     = st.rdata;
   assign o_gp_out    = st.line_out;
   assign o_gp_oe     = st.line_oe;
   assign o_acq_start = st.acq_start;
   assign o_nv        = st.nv;
   assign o_log_valid = st.log_valid;
   assign o_log_temps = st.log_temps;
endmodule : temperature_alarm_dio_unit

// ===== gp_equipment.sv
// Purpose: External equipment on the general-purpose lines.
// Assumes: Every line carries a pull-up; equipment drives only where enabled.
// Notes:   The resolved level feeds the device input sampler.
`timescale 1ns/1ps
module gp_equipment (
   input  wire logic [7:0] i_gp_out,
   input  wire logic [7:0] i_gp_oe,
   input  wire logic [7:0] i_ext_val,
   input  wire logic [7:0] i_ext_en,
   output logic      [7:0] o_level
);
   // Device drive first, then equipment, else the pull-up
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         o_level[k] = i_gp_oe[k] ? i_gp_out[k] : (i_ext_en[k] ? i_ext_val[k] : 1'b1);
      end
   end
endmodule : gp_equipment

// ===== temperature_alarm_dio_unit_assertions.sv
// Purpose: Port-level checks of the alarm and line unit.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Pulse spacing is counted in helper logic.
`timescale 1ns/1ps
module alarm_dio_checker #(
   parameter int HALF_SEC_CYCLES = alarm_pkg::HALF_SEC_CYCLES
) (
   input  wire logic               i_clk,
   input  wire logic               i_resetn,
   input  wire logic [7:0]         i_addr,
   input  wire logic [15:0]        i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   input  wire logic [15:0]        o_rdata,
   input  wire logic [7:0]         o_gp_out,
   input  wire logic [7:0]         o_gp_oe,
   input  wire logic               o_acq_start,
   input  wire alarm_pkg::nv_req_s o_nv,
   input  wire logic               i_host_attached,
   input  wire logic               i_log_run,
   input  wire logic               o_log_valid
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   int   acnt;
   int   lcnt;
   logic aseen;
   logic lseen;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         acnt  <= 0;
         lcnt  <= 0;
         aseen <= 1'b0;
         lseen <= 1'b0;
      end else begin
         acnt  <= o_acq_start ? 0 : acnt + 1;
         lcnt  <= o_log_valid ? 0 : lcnt + 1;
         aseen <= aseen | o_acq_start;
         lseen <= lseen | o_log_valid;
      end
   end
   ////////////////////////////////////////////////////////////////
   sequence s_nv_first;
      o_nv.rd && o_nv.addr == 5'h00;
   endsequence
   sequence s_nv_second;
      o_nv.rd && o_nv.addr == 5'h01;
   endsequence
   AST_OE_AT_RESET: assert property ($rose(i_resetn) |-> o_gp_oe == 8'h00 && o_gp_out == 8'h00)
      else $error("line enable not clear after reset");
   AST_OE_IN_LOAD: assert property (o_nv.rd |-> o_gp_oe == 8'h00)
      else $error("line driven before config load");
   AST_NV_START: assert property ($rose(i_resetn) |-> ##[1:2] s_nv_first ##1 s_nv_second)
      else $error("config load did not start");
   AST_NV_STEP: assert property (o_nv.rd && o_nv.addr != 5'h17 |=>
      o_nv.rd && o_nv.addr == $past(o_nv.addr) + 5'h01)
      else $error("config load skipped a word");
   AST_NV_WRITE: assert property (o_nv.wr |-> $past(i_wr) && o_nv.addr == $past(i_addr[4:0])
      && o_nv.wdata == $past(i_wdata))
      else $error("store write not from register write");
   AST_ACQ_PERIOD: assert property (o_acq_start && aseen |-> acnt == HALF_SEC_CYCLES - 1)
      else $error("acquisition spacing wrong");
   AST_LOG_SPACING: assert property (o_log_valid && lseen |-> lcnt >= 2 * HALF_SEC_CYCLES - 1)
      else $error("log entries too close");
   AST_LOG_HOST: assert property (o_log_valid |-> !$past(i_host_attached) && $past(i_log_run))
      else $error("log entry while host attached or stopped");
   AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside read answer");
endmodule : alarm_dio_checker

bind temperature_alarm_dio_unit alarm_dio_checker #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) chk_u (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_gp_out(o_gp_out), .o_gp_oe(o_gp_oe), .o_acq_start(o_acq_start),
   .o_nv(o_nv), .i_host_attached(i_host_attached), .i_log_run(i_log_run), .o_log_valid(o_log_valid));

// ===== temperature_alarm_dio_unit_test.sv
// Purpose: Self-checking bench of the alarm and line unit.
// Assumes: Store answers one cycle after a read; samples follow each acquisition pulse.
// Notes:   Short half-second count keeps the run small.
`timescale 1ns/1ps
module temperature_alarm_dio_unit_test;
   localparam int HALF = 20;
   typedef struct {logic [7:0][15:0] t; logic [7:0] line; logic [7:0] alm;} row_s;
   logic               i_clk, i_resetn, i_wr, i_rd, i_host_attached, i_log_run, o_acq_start, o_log_valid;
   logic [7:0]         i_addr, i_gp_in, o_gp_out, o_gp_oe, ext_val, ext_en;
   logic [15:0]        i_wdata, o_rdata, i_nv_rdata, rd_val;
   logic [7:0][15:0]   o_log_temps, temps;
   logic [3:0]         scnt;
   alarm_pkg::sample_s i_sample;
   alarm_pkg::nv_req_s o_nv;
   logic [15:0]        nv_mem [24];
   row_s               rows [4];
   int                 miscompares, tests_run;
   temperature_alarm_dio_unit #(.HALF_SEC_CYCLES(HALF)) dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gp_in(i_gp_in),
      .o_gp_out(o_gp_out), .o_gp_oe(o_gp_oe), .o_acq_start(o_acq_start), .i_sample(i_sample), .o_nv(o_nv),
      .i_nv_rdata(i_nv_rdata), .i_host_attached(i_host_attached), .i_log_run(i_log_run),
      .o_log_valid(o_log_valid), .o_log_temps(o_log_temps));
   gp_equipment eq_u (.i_gp_out(o_gp_out), .i_gp_oe(o_gp_oe), .i_ext_val(ext_val), .i_ext_en(ext_en),
      .o_level(i_gp_in));
   ////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // Store answers the cycle after a read; scrambled otherwise
   always @(posedge i_clk) begin
      i_nv_rdata <= o_nv.rd ? nv_mem[o_nv.addr] : ~i_nv_rdata;
      if (o_nv.wr) nv_mem[o_nv.addr] <= o_nv.wdata;
      i_sample   <= '{valid: !scnt[3], chan: scnt[2:0], data: temps[scnt[2:0]]};
      scnt       <= o_acq_start ? 4'h0 : (scnt[3] ? scnt : scnt + 4'h1);
   end
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rd_val = o_rdata;
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic wait_load;
      int n;
      for (n = 0; n < 60; n++) begin
         rd(8'h24);
         if (rd_val[0] === 1'b1) break;
      end
      if (n == 60) begin
         miscompares++;
         give_verdict();
      end
   endtask : wait_load
   task automatic wait_log;
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge i_clk);
         #1;
         if (o_log_valid === 1'b1) break;
      end
      if (n == 200) begin
         miscompares++;
         give_verdict();
      end
   endtask : wait_log
   ////////////////////////////////////////////////////////////////
   initial begin
      nv_mem = '{16'h0001, 16'h0026, 16'h0049, 16'h006D, 16'h0091, 16'h00A0, 16'h0001, 16'h00E3,
                 16'h0064, 16'h0064, 16'h0000, 16'hFFF6, 16'h0000, 16'h0000, 16'h00C8, 16'h7FFF,
                 16'h0000, 16'h0032, 16'h0000, 16'h000A, 16'h0064, 16'h0000, 16'h0000, 16'h0000};
      rows[0] = '{{48'h0, 16'h0096, 16'hFFEC, 16'hFFFB, 16'h0096, 16'h0096}, 8'h1D, 8'h1F};
      rows[1] = '{{48'h0, 16'h0032, 16'h0000, 16'h0000, 16'h0046, 16'h0064}, 8'h08, 8'h0A};
      rows[2] = '{{48'h0, 16'hFFFF, 16'h000B, 16'hFFFF, 16'h0028, 16'h00FA}, 8'h57, 8'h55};
      rows[3] = '{{48'h0, 16'h0064, 16'h0000, 16'h0005, 16'h0046, 16'h0000}, 8'h02, 8'h00};
      {i_resetn, i_wr, i_rd, i_host_attached, i_log_run, scnt} = {5'h00, 4'h8};
      {i_addr, i_wdata, ext_val, ext_en, temps} = {8'h00, 16'h0000, 8'h00, 8'h20, 128'h0};
      repeat (6) @(posedge i_clk);
      i_resetn  <= 1'b1;
      i_log_run <= 1'b1;
      wait_load();
      chk8(o_gp_oe, 8'h5F);
      rd(8'h01);
      chk16(rd_val, 16'h0026);
      rd(8'h09);
      chk16(rd_val, 16'h0064);
      rd(8'h30);
      chk16(rd_val, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk);
         i_host_attached <= (i >= 2);
         temps           <= rows[i].t;
         repeat (4 * HALF + 4) @(posedge i_clk);
         #1 chk8(o_gp_out & 8'h5F, rows[i].line);
         rd(8'h23);
         chk8(rd_val[7:0], rows[i].alm);
         rd(8'h19);
         chk16(rd_val, rows[i].t[1]);
         if (i == 1) begin
            wait_log();
            chk16(o_log_temps[1], rows[1].t[1]);
         end
      end
      rd(8'h22);
      chk8(rd_val[7:0], 8'h82);
      @(posedge i_clk);
      ext_en <= 8'h00;
      wr(8'h20, 16'h00A0);
      wr(8'h21, 16'h0020);
      repeat (3) @(posedge i_clk);
      #1 chk8(o_gp_oe, 8'hFF);
      chk8(o_gp_out & 8'hA0, 8'h20);
      wr(8'h0E, 16'h0096);
      #1 chk16(o_nv.wdata, 16'h0096);
      chk8({o_nv.wr, 2'h0, o_nv.addr}, 8'h8E);
      rd(8'h0E);
      chk16(rd_val, 16'h0096);
      @(posedge i_clk);
      i_resetn <= 1'b0;
      repeat (6) @(posedge i_clk);
      #1 chk8(o_gp_oe, 8'h00);
      @(posedge i_clk);
      i_resetn <= 1'b1;
      wait_load();
      chk8(o_gp_oe, 8'h5F);
      rd(8'h0E);
      chk16(rd_val, 16'h0096);
      give_verdict();
   end
endmodule : temperature_alarm_dio_unit_test
